// File: rtl/spc_top.sv
// Sector write protection control: write protect pin filter, command
// protection state, sixteen byte protection map and its update commands.
// Assumes a serial host on sck/csN/si and a 25 MHz system clock.
//
// Operation
// [R1] Floating write protect pin reads released through the pad pull-up.
// [R2] Command protection state is cleared at every power-up reset.
// [R3] Pin asserted: protected sectors and the map itself are read only.
// [R4] Asserting the pin enables protection within the enable delay.
// [R5] Releasing the pin drops protection unless enabled by command.
// [R6] Command enable keeps protection on after the pin is released.
// [R7] Disable command is ignored while the pin is asserted.
// [R8] Short noise pulses on the pin are filtered out.
// [R9] Sixteen map bytes, one per sector; FF protects, 00 unprotects.
// [R10] Sector zero: bits 7:6 low part, bits 5:4 high part.
// [R11] The map must be erased before it is reprogrammed.
// [R12] 3D 2A 7F CF then chip select high erases the map, busy meanwhile.
// [R13] Map erase sets every byte to FF.
// [R14] Map erase is accepted with protection enabled or disabled.
// [R15] 3D 2A 7F FC then sixteen bytes, stored from sector 0 upward.
// [R16] Chip select high after data starts a timed program, busy meanwhile.
// [R17] More than sixteen data bytes wrap back to location zero.
// [R18] Host sends all sixteen bytes; missing ones leave sectors undefined.
// [R19] Host writes only 00 or FF into each map byte.
// [R20] Map programming is accepted while protection is enabled.
// [R21] Map data is staged in data buffer one, overwriting it.
// [R22] 3D 2A 7F A9 then chip select high sets command protection.
// [R23] 3D 2A 7F 9A clears command protection only with the pin released.
// [R24] Bytes are MSB first, sampled on rising serial clock edges.
`timescale 1ns/1ps
module spc_top
  import spc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        sck,
  input  wire logic        csN,
  input  wire logic        si,
  input  wire logic        wpN,
  input  wire logic [11:0] queryPage,
  input  wire logic [3:0]  mapRdIdx,
  output      logic        busy,
  output      logic        protectOn,
  output      logic        swProtect,
  output      logic        wpHeld,
  output      logic        queryProtected,
  output      logic [7:0]  mapRdData
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release and link side

  logic [1:0] rstPipe;
  logic       rstN;
  logic       syncTog;
  logic       syncCsN;
  logic       syncWpN;
  spc_byte_if byteLink ();

  // Reset leaves through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstN = rstPipe[1];

  spc_serial_rx u_rx (
    .sck  (sck),
    .csN  (csN),
    .si   (si),
    .rstN (rstN),
    .link (byteLink.tx)
  );

  // [R1] pulled-up pin idles released
  spc_sync #(.W(3), .INIT(3'b011)) u_sync (
    .clk  (clk),
    .rstN (rstN),
    .d    ({byteLink.byteTog, csN, wpN}),
    .q    ({syncTog, syncCsN, syncWpN})
  );

  ////////////////////////////////////////////////////////////////////////
  // State of the system clock side

  logic       togPrev;
  logic       csD1;
  logic       csD2;
  logic [2:0] fltCnt;
  logic [2:0] next_fltCnt;
  logic       next_wpHeld;
  logic [2:0] byteCnt;
  logic [2:0] next_byteCnt;
  logic       prefixOk;
  logic       next_prefixOk;
  logic [7:0] opByte;
  logic [7:0] next_opByte;
  logic [3:0] dataPtr;
  logic [3:0] next_dataPtr;
  logic [7:0] bufOne [MAP_BYTES];
  logic [7:0] next_bufOne [MAP_BYTES];
  logic [7:0] map [MAP_BYTES];
  logic [7:0] next_map [MAP_BYTES];
  spc_state_e state;
  spc_state_e next_state;
  logic [11:0] timer;
  logic [11:0] next_timer;
  logic       next_swProtect;
  logic       next_busy;
  logic       next_protectOn;
  logic       next_queryProtected;
  logic [7:0] next_mapRdData;

  logic       byteEvt;
  logic       frameEnd;
  logic       hdrExact;
  logic       cmdEnable;
  logic       cmdDisable;
  logic       cmdErase;
  logic       cmdProgram;
  logic       progFrame;
  logic       timerDone;
  logic [7:0] qByte;

  // Frame events seen in system clock time
  assign byteEvt   = syncTog != togPrev;
  assign frameEnd  = csD1 & ~csD2;
  assign hdrExact  = prefixOk && (byteCnt == CNT_DATA);
  assign progFrame = prefixOk && (byteCnt >= CNT_DATA)
                     && (opByte == OP_PROGRAM);
  assign cmdEnable  = frameEnd && hdrExact && (opByte == OP_ENABLE);
  assign cmdDisable = frameEnd && hdrExact && (opByte == OP_DISABLE);
  assign cmdErase   = frameEnd && hdrExact && (opByte == OP_ERASE);
  assign cmdProgram = frameEnd && progFrame;
  assign timerDone  = (state != ST_IDLE) && (timer == 12'h000);

  ////////////////////////////////////////////////////////////////////////
  // [R8] write protect noise filter
  always_comb begin
    next_fltCnt = 3'h0;
    next_wpHeld = wpHeld;
    if (syncWpN == wpHeld) begin
      next_fltCnt = fltCnt + 3'h1;
      if (fltCnt == 3'(WP_FILTER_CYC - 1)) begin
        next_fltCnt = 3'h0;
        next_wpHeld = ~syncWpN;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode and protection state
  always_comb begin
    next_byteCnt   = byteCnt;
    next_prefixOk  = prefixOk;
    next_opByte    = opByte;
    next_dataPtr   = dataPtr;
    next_bufOne    = bufOne;
    next_swProtect = swProtect;
    if (byteEvt) begin
      if (byteCnt != CNT_SAT) begin
        next_byteCnt = byteCnt + 3'h1;
      end
      case (byteCnt)
        3'h0:    next_prefixOk = byteLink.byteData == OP_PREFIX_A;
        3'h1:    next_prefixOk = prefixOk
                                 && byteLink.byteData == OP_PREFIX_B;
        3'h2:    next_prefixOk = prefixOk
                                 && byteLink.byteData == OP_PREFIX_C;
        3'h3:    next_opByte   = byteLink.byteData;
        default: begin
          // [R21] staging in buffer one
          if (progFrame && state == ST_IDLE) begin
            next_bufOne[dataPtr] = byteLink.byteData;
            // [R17] pointer wraps at sixteen
            next_dataPtr = dataPtr + 4'h1;
          end
        end
      endcase
    end
    if (frameEnd) begin
      next_byteCnt  = 3'h0;
      next_prefixOk = 1'b0;
      next_dataPtr  = 4'h0;
    end
    // [R22] enable command sets state
    if (cmdEnable) begin
      next_swProtect = 1'b1;
    end
    // [R7] [R23] disable needs pin released
    if (cmdDisable && !wpHeld) begin
      next_swProtect = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Map erase and program engine
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_map   = map;
    case (state)
      ST_IDLE: begin
        // [R3] map locked while pin held
        // [R14] erase with either state
        if (cmdErase && !wpHeld) begin
          next_state = ST_ERASE;
          next_timer = 12'(MAP_ERASE_CYC - 1);
        end
        // [R20] program with either state
        if (cmdProgram && !wpHeld) begin
          next_state = ST_PROGRAM;
          next_timer = 12'(MAP_PROGRAM_CYC - 1);
        end
      end
      ST_ERASE: begin
        next_timer = timer - 12'h001;
        if (timerDone) begin
          // [R13] erased bytes protect
          for (int i = 0; i < MAP_BYTES; i++) begin
            next_map[i] = MAP_ERASED;
          end
          next_state = ST_IDLE;
          next_timer = 12'h000;
        end
      end
      ST_PROGRAM: begin
        next_timer = timer - 12'h001;
        if (timerDone) begin
          // [R11] [R15] bits only clear
          for (int i = 0; i < MAP_BYTES; i++) begin
            next_map[i] = map[i] & bufOne[i];
          end
          next_state = ST_IDLE;
          next_timer = 12'h000;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_timer = 12'h000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs: status, sector query and map readback
  always_comb begin
    qByte = map[queryPage[11:8]];
    // [R12] [R16] busy through timed cycle
    next_busy = next_state != ST_IDLE;
    // [R4] [R5] [R6] pin or command
    next_protectOn = wpHeld | swProtect;
    // [R9] [R10] sector and part select
    if (queryPage[11:8] == 4'h0 && queryPage[7:3] != 5'h00) begin
      next_queryProtected = protectOn & qByte[MAP_BIT_HIGH];
    end else begin
      next_queryProtected = protectOn & qByte[MAP_BIT_MAIN];
    end
    next_mapRdData = map[mapRdIdx];
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      togPrev        <= 1'b0;
      csD1           <= 1'b1;
      csD2           <= 1'b1;
      fltCnt         <= 3'h0;
      wpHeld         <= 1'b0;
      byteCnt        <= 3'h0;
      prefixOk       <= 1'b0;
      opByte         <= 8'h00;
      dataPtr        <= 4'h0;
      state          <= ST_IDLE;
      timer          <= 12'h000;
      // [R2] cleared at power-up
      swProtect      <= 1'b0;
      busy           <= 1'b0;
      protectOn      <= 1'b0;
      queryProtected <= 1'b0;
      mapRdData      <= 8'h00;
      for (int i = 0; i < MAP_BYTES; i++) begin
        bufOne[i] <= 8'h00;
        map[i]    <= MAP_RESET;
      end
    end else begin
      togPrev        <= syncTog;
      csD1           <= syncCsN;
      csD2           <= csD1;
      fltCnt         <= next_fltCnt;
      wpHeld         <= next_wpHeld;
      byteCnt        <= next_byteCnt;
      prefixOk       <= next_prefixOk;
      opByte         <= next_opByte;
      dataPtr        <= next_dataPtr;
      state          <= next_state;
      timer          <= next_timer;
      swProtect      <= next_swProtect;
      busy           <= next_busy;
      protectOn      <= next_protectOn;
      queryProtected <= next_queryProtected;
      mapRdData      <= next_mapRdData;
      bufOne         <= next_bufOne;
      map            <= next_map;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  // Pin synchronised low for long enough
  sequence s_wp_low;
    $fell(syncWpN) ##1 !syncWpN [*6];
  endsequence

  // Single cycle glitch on a released pin
  sequence s_wp_glitch;
    !wpHeld && $fell(syncWpN) ##1 syncWpN;
  endsequence

  // Erase accepted on an idle engine
  sequence s_erase_start;
    state == ST_IDLE && cmdErase && !wpHeld;
  endsequence

  a_wp_enables: assert property ( // [R4]
    @(posedge clk) disable iff (!rstN)
    s_wp_low |=> protectOn)
    else $error("protection not on after pin held low");

  a_wp_glitch_filtered: assert property ( // [R8]
    @(posedge clk) disable iff (!rstN)
    s_wp_glitch |=> !wpHeld [*4])
    else $error("short pin pulse reached protection");

  a_disable_ignored_wp: assert property ( // [R7]
    @(posedge clk) disable iff (!rstN)
    cmdDisable && wpHeld |=> swProtect == $past(swProtect))
    else $error("disable acted while pin asserted");

  a_disable_clears: assert property ( // [R23]
    @(posedge clk) disable iff (!rstN)
    cmdDisable && !wpHeld && !cmdEnable |=> !swProtect)
    else $error("disable did not clear protection");

  a_enable_sets: assert property ( // [R22]
    @(posedge clk) disable iff (!rstN)
    cmdEnable |=> swProtect ##1 protectOn)
    else $error("enable did not set protection");

  a_map_locked_wp: assert property ( // [R3]
    @(posedge clk) disable iff (!rstN)
    state == ST_IDLE && frameEnd && wpHeld |=> state == ST_IDLE)
    else $error("map update started with pin asserted");

  a_erase_busy_time: assert property ( // [R12]
    @(posedge clk) disable iff (!rstN)
    s_erase_start |=> busy [*8] ##[1:1000] (!busy && map[0] == MAP_ERASED))
    else $error("erase busy window wrong");

  a_erase_all_ff: assert property ( // [R13]
    @(posedge clk) disable iff (!rstN)
    state == ST_ERASE && timerDone
    |=> map[0] == MAP_ERASED && map[15] == MAP_ERASED && !busy)
    else $error("erase did not set map to all ones");

  a_program_copies: assert property ( // [R15]
    @(posedge clk) disable iff (!rstN)
    state == ST_PROGRAM && timerDone
    |=> map[0] == ($past(map[0]) & $past(bufOne[0]))
        && map[15] == ($past(map[15]) & $past(bufOne[15])))
    else $error("program did not copy staged bytes");

  a_pointer_wraps: assert property ( // [R17]
    @(posedge clk) disable iff (!rstN)
    byteEvt && !frameEnd && progFrame && state == ST_IDLE
    && dataPtr == 4'hF |=> dataPtr == 4'h0)
    else $error("data pointer did not wrap");

endmodule

// File: rtl/spc_pkg.sv
// Shared constants for the sector protection control block.
// Assumes a 25 MHz system clock; all clock cycle counts derive from its period.
package spc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Command bytes, shifted in most significant bit first
  localparam logic [7:0] OP_PREFIX_A = 8'h3D;
  localparam logic [7:0] OP_PREFIX_B = 8'h2A;
  localparam logic [7:0] OP_PREFIX_C = 8'h7F;
  localparam logic [7:0] OP_ENABLE   = 8'hA9;
  localparam logic [7:0] OP_DISABLE  = 8'h9A;
  localparam logic [7:0] OP_ERASE    = 8'hCF;
  localparam logic [7:0] OP_PROGRAM  = 8'hFC;

  ////////////////////////////////////////////////////////////////////////
  // Protection map layout and values
  localparam int         MAP_BYTES     = 16;
  localparam logic [7:0] MAP_ERASED    = 8'hFF;
  localparam logic [7:0] MAP_RESET     = 8'h00;
  localparam int         MAP_BIT_MAIN  = 7;   // Sector 1..15, and low part
  localparam int         MAP_BIT_HIGH  = 5;   // Sector zero high part
  localparam logic [2:0] CNT_DATA      = 3'h4; // Bytes before map data
  localparam logic [2:0] CNT_SAT       = 3'h5;

  ////////////////////////////////////////////////////////////////////////
  // Timing, times in ns and counts in clock cycles
  localparam int CLK_PERIOD_NS            = 40;
  localparam int WP_FILTER_NS             = 200;
  localparam int WP_FILTER_CYC            =
    (WP_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROTECT_ENABLE_DELAY_NS  = 1000;
  localparam int PROTECT_DISABLE_DELAY_NS = 1000;
  localparam int MAP_ERASE_TIME_NS        = 40000;
  localparam int MAP_ERASE_CYC            =
    (MAP_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAP_PROGRAM_TIME_NS      = 40000;
  localparam int MAP_PROGRAM_CYC          =
    (MAP_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////
  // Map update engine states
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROGRAM} spc_state_e;

endpackage

// File: rtl/spc_byte_if.sv
// Byte hand-over from the serial clock side to the system clock side.
// Data is held stable until the next toggle of byteTog.
`timescale 1ns/1ps
interface spc_byte_if;
  logic       byteTog;
  logic [7:0] byteData;
  modport tx (output byteTog, output byteData);
  modport rx (input  byteTog, input  byteData);
endinterface

// File: rtl/spc_sync.sv
// Two flip-flop level synchroniser, one bit per lane.
// Assumes each lane is a level that is stable for several clocks.
`timescale 1ns/1ps
module spc_sync
  import spc_pkg::*;
#(
  parameter int               W    = 1,
  parameter logic [W-1:0]     INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rstN,
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// File: rtl/spc_serial_rx.sv
// Serial byte receiver running on the link's own serial clock.
// Assumes chip select high between frames; the clock may stop then.
`timescale 1ns/1ps
module spc_serial_rx
  import spc_pkg::*;
(
  input  wire logic sck,
  input  wire logic csN,
  input  wire logic si,
  input  wire logic rstN,
  spc_byte_if.tx    link
);
  logic [2:0] bitCnt;
  logic [2:0] next_bitCnt;
  logic [6:0] shift;
  logic [6:0] next_shift;
  logic       tog;
  logic       next_tog;
  logic [7:0] data;
  logic [7:0] next_data;

  ////////////////////////////////////////////////////////////////////////
  // [R24] MSB first on rising edges
  always_comb begin
    next_shift  = {shift[5:0], si};
    next_bitCnt = bitCnt + 3'h1;
    next_tog    = tog;
    next_data   = data;
    if (bitCnt == 3'h7) begin
      next_tog  = ~tog;
      next_data = {shift, si};
    end
  end

  // Bit position restarts whenever chip select is high
  always_ff @(posedge sck or posedge csN) begin
    if (csN) begin
      bitCnt <= 3'h0;
      shift  <= 7'h00;
    end else begin
      bitCnt <= next_bitCnt;
      shift  <= next_shift;
    end
  end

  // Toggle survives frames so no event is invented at a frame edge
  always_ff @(posedge sck or negedge rstN) begin
    if (!rstN) begin
      tog  <= 1'b0;
      data <= 8'h00;
    end else begin
      tog  <= next_tog;
      data <= next_data;
    end
  end

  assign link.byteTog  = tog;
  assign link.byteData = data;
endmodule

// File: tb/spc_host_model.sv
// Host serial controller model for the sector protection block.
// Assumes mode 0: clock idles low and stands still between frames.
`timescale 1ns/1ps
module spc_host_model (
  output logic sck,
  output logic csN,
  output logic si
);
  ////////////////////////////////////////////////////////////////////////
  // Idle link levels at time zero
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    si  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One whole frame of n bytes at a 160 ns serial period
  // bytes then chip select released
  task automatic sendFrame(input logic [7:0] b [24], input int n);
    #13;
    csN = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      // MSB first, data set up before rising edge
      for (int k = 7; k >= 0; k--) begin
        si = b[i][k];
        #80 sck = 1'b1;
        #80 sck = 1'b0;
      end
    end
    #120 csN = 1'b1;
    si = ~si;  // Released line shows no stale value
    #200;
  endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the sector protection control block.
// Assumes the host model on the link; pins change at the clock's fall.
`timescale 1ns/1ps
module testbench;
  import spc_pkg::*;

  typedef struct {
    logic [7:0] op;
    logic       wp;
    logic       expPre;
    logic       expSw;
  } spc_row_s;

  logic        clk;
  logic        arstN;
  logic        wpN;
  logic [11:0] queryPage;
  logic [3:0]  mapRdIdx;
  logic        sck;
  logic        csN;
  logic        si;
  logic        busy;
  logic        protectOn;
  logic        swProtect;
  logic        wpHeld;
  logic        queryProtected;
  logic [7:0]  mapRdData;
  logic [7:0]  fb [24];
  spc_row_s    rows [5];
  int          fails;
  int          n_compared;

  ////////////////////////////////////////////////////////////////////////
  // Design and host
  spc_top dut (
    .clk(clk), .arst_n(arstN), .sck(sck), .csN(csN), .si(si),
    .wpN(wpN), .queryPage(queryPage), .mapRdIdx(mapRdIdx),
    .busy(busy), .protectOn(protectOn), .swProtect(swProtect),
    .wpHeld(wpHeld), .queryProtected(queryProtected),
    .mapRdData(mapRdData)
  );

  spc_host_model host (.sck(sck), .csN(csN), .si(si));

  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic waitClk(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Four byte command with the common prefix
  task automatic cmd(input logic [7:0] op);
    fb[0] = OP_PREFIX_A;
    fb[1] = OP_PREFIX_B;
    fb[2] = OP_PREFIX_C;
    fb[3] = op;
    host.sendFrame(fb, 4);
    waitClk(4);
  endtask

  task automatic readMap(input logic [3:0] idx, input logic [7:0] exp);
    mapRdIdx = idx;
    waitClk(2);
    chk(mapRdData, exp, "map byte");
  endtask

  task automatic query(input logic [11:0] pg, input logic exp);
    queryPage = pg;
    waitClk(3);
    chk(queryProtected, exp, "page query");
  endtask

  // Bounded wait for the protection flag to reach a level
  task automatic waitOn(input logic exp, input int lim);
    int t;
    t = 0;
    while (protectOn !== exp && t < lim) begin
      waitClk(1);
      t++;
    end
    chk(protectOn, exp, "protect delay");
    if (protectOn !== exp) begin
      test_done();
    end
  endtask

  // Bounded wait for a self-timed map update, with its length
  task automatic runOp(input int cyc);
    int t;
    t = 0;
    chk(busy, 1'b1, "busy start");
    while (busy === 1'b1 && t < 1100) begin
      waitClk(1);
      t++;
    end
    if (t >= 1100) begin
      fails++;
      $display("[FAIL] %0t busy never fell", $time);
      test_done();
    end
    chk(t >= cyc - 20 && t <= cyc, 1'b1, "busy length");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    fails = 0;
    n_compared = 0;
    wpN = 1'b1;
    queryPage = 12'h000;
    mapRdIdx = 4'h0;
    arstN = 1'b0;
    rows = '{'{OP_ENABLE, 1'b1, 1'b0, 1'b1},
             '{OP_DISABLE, 1'b1, 1'b1, 1'b0},
             '{OP_ENABLE, 1'b0, 1'b1, 1'b1},
             '{OP_DISABLE, 1'b0, 1'b1, 1'b1},
             '{OP_DISABLE, 1'b1, 1'b1, 1'b0}};
    waitClk(5);
    arstN = 1'b1;
    waitClk(6);
    chk(swProtect, 1'b0, "power-up state");
    // Pin and command table
    foreach (rows[i]) begin
      wpN = rows[i].wp;
      waitClk(15);
      chk(protectOn, rows[i].expPre, "before frame");
      chk(wpHeld, !rows[i].wp, "pin level");
      cmd(rows[i].op);
      waitClk(6);
      chk(swProtect, rows[i].expSw, "command state");
      chk(protectOn, rows[i].expSw || !rows[i].wp, "after frame");
    end
    // Noise pulses of one to four clocks on the pin are filtered
    for (int p = 1; p <= 4; p++) begin
      wpN = 1'b0;
      waitClk(p);
      wpN = 1'b1;
      repeat (10) begin
        waitClk(1);
        chk(wpHeld, 1'b0, "noise pulse");
      end
    end
    // Pin alone enables and drops protection within 25 cycles
    wpN = 1'b0;
    waitOn(1'b1, 25);
    wpN = 1'b1;
    waitOn(1'b0, 25);
    // Map erase with protection enabled
    cmd(OP_ENABLE);
    cmd(OP_ERASE);
    runOp(MAP_ERASE_CYC);
    for (int i = 0; i < MAP_BYTES; i++) begin
      readMap(i[3:0], MAP_ERASED);
    end
    // Program seventeen bytes; the last wraps onto sector zero
    fb[3] = OP_PROGRAM;
    for (int i = 0; i < MAP_BYTES; i++) begin
      fb[4 + i] = i[0] ? 8'hFF : 8'h00;
    end
    fb[20] = 8'h30;
    host.sendFrame(fb, 21);
    waitClk(4);
    runOp(MAP_PROGRAM_CYC);
    readMap(4'h0, 8'h30);
    for (int i = 1; i < MAP_BYTES; i++) begin
      readMap(i[3:0], i[0] ? 8'hFF : 8'h00);
    end
    query(12'h005, 1'b0);
    query(12'h009, 1'b1);
    query(12'h1FF, 1'b1);
    query(12'h200, 1'b0);
    // Without an erase, programming cannot raise protection
    for (int i = 4; i < 20; i++) begin
      fb[i] = 8'hFF;
    end
    host.sendFrame(fb, 20);
    waitClk(4);
    runOp(MAP_PROGRAM_CYC);
    readMap(4'h2, 8'h00);
    // Pin asserted: the map is read only
    wpN = 1'b0;
    waitClk(15);
    cmd(OP_ERASE);
    chk(busy, 1'b0, "erase refused");
    readMap(4'h2, 8'h00);
    // Reset in mid-run clears the command state
    wpN = 1'b1;
    waitClk(15);
    arstN = 1'b0;
    waitClk(3);
    arstN = 1'b1;
    waitClk(6);
    chk(swProtect, 1'b0, "state after reset");
    chk(protectOn, 1'b0, "protect after reset");
    test_done();
  end
endmodule
